// File: src/dtc_mgr_pkg.sv
// Purpose: Constants, types and helpers of the trouble code manager
// Assumes: 40 MHz core clock, at most 8 diagnostic events
// Notes:   How it works is listed below
//
// How it works
// - No DM1 until 5 s after reset
// - Keep occurrence count per linked fault
// - New fault starts qualification countdown
// - Fault held through delay: active, count+1
// - Newly active code sends DM1 at once
// - Default: gone fault becomes previously active
// - Latch option keeps code until DM11 clear
// - Lamp byte leads every DM1
// - Lamp codes: protect, amber, red, malfunction
// - Amber lamp is the default
// - Zero parameter number sends nothing
// - Parameter number change zeroes occurrence count
// - Failure mode defaults; only 0-21, 31 accepted
// - Four byte code, conversion bit zero
// - Empty DM1 when none; send at last clear
// - Several active codes use multipacket transfer
package dtc_mgr_pkg;

  // ****************************************************************
  // Sizes and timing
  // ****************************************************************
  localparam int N_EVENTS     = 8;
  localparam int CLK_HZ       = 40_000_000;
  localparam int TICK_MS      = 1;
  localparam int TICK_CYC     = CLK_HZ / 1000 * TICK_MS;
  localparam int HOLDOFF_MS   = 5000;
  localparam int HOLDOFF_CYC  = HOLDOFF_MS * TICK_CYC;
  localparam int PERIOD_MS    = 1000;
  localparam int PERIOD_CYC   = PERIOD_MS * TICK_CYC;

  // ****************************************************************
  // Register offsets and fields
  // ****************************************************************
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h000;
  localparam logic [11:0] ADDR_IRQ_MASK   = 12'h004;
  localparam logic [11:0] ADDR_STATE      = 12'h008;
  localparam logic [11:0] ADDR_COMMAND    = 12'h00c;
  localparam logic [11:0] ADDR_EVENT_BASE = 12'h040;
  localparam int CTRL_LAMP_LSB  = 5;
  localparam int CTRL_LATCH_BIT = 7;
  localparam int CTRL_DELAY_LSB = 8;
  localparam int CTRL_OC_LSB    = 24;
  localparam int CMD_CLR_ACTIVE = 0;
  localparam int CMD_CLR_PREV   = 1;
  localparam int CMD_SEND_DM1   = 2;
  localparam int IRQ_NEW_ACTIVE = 0;
  localparam int IRQ_ALL_CLEAR  = 1;
  localparam int IRQ_MSG_DONE   = 2;
  localparam int IRQ_W          = 3;

  // ****************************************************************
  // Reset values and limits
  // ****************************************************************
  localparam logic [18:0] SPN_RESET   = 19'h00000;
  localparam logic [4:0]  FMI_RESET   = 5'h1f;
  localparam logic [15:0] DELAY_RESET = 16'h03e8;
  localparam logic [6:0]  OC_MAX      = 7'h7e;
  localparam logic [4:0]  FMI_LAST    = 5'h15;
  localparam logic [4:0]  FMI_EXISTS  = 5'h1f;

  typedef enum logic [1:0] {LAMP_PROTECT, LAMP_AMBER, LAMP_RED, LAMP_MIL} lamp_sel_e;

  typedef struct packed {
    logic [18:0] spn;
    logic [4:0]  fmi;
    lamp_sel_e   lamp;
    logic        latch;
    logic [15:0] delay;
  } event_cfg_s;

  typedef struct packed {
    logic        first;
    logic        last;
    logic        multipacket;
    logic [7:0]  lamp;
    logic [3:0]  count;
    logic [31:0] dtc;
  } dm1_beat_s;

  // Accepted failure mode codes
  function automatic logic fmi_legal(input logic [4:0] f);
    fmi_legal = (f <= FMI_LAST) || (f == FMI_EXISTS);
  endfunction : fmi_legal

endpackage : dtc_mgr_pkg

// File: src/dtc_event_qualifier.sv
// Purpose: Qualifies one fault input into an active trouble code
// Assumes: tick pulses once per millisecond
// Notes:   rise and fall are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module dtc_event_qualifier import dtc_mgr_pkg::*; (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        core_ce,
  // Event inputs
  input  wire logic        tick,
  input  wire logic        fault,
  input  wire logic [15:0] qual_delay,
  input  wire logic        latch,
  input  wire logic        clear_req,
  // Results
  output logic             active,
  output logic             rise,
  output logic             fall
);

  typedef enum logic [1:0] {QUAL_IDLE, QUAL_COUNT, QUAL_ACTIVE, QUAL_LATCHED} qual_state_e;
  qual_state_e state_reg;
  logic [15:0] cnt_reg;

  // ****************************************************************
  // Qualification state machine
  // ****************************************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= QUAL_IDLE;
      cnt_reg   <= 16'h0000;
      rise      <= 1'b0;
      fall      <= 1'b0;
    end else if (core_ce) begin
      rise <= 1'b0;
      fall <= 1'b0;
      unique case (state_reg)
        QUAL_IDLE: begin
          if (fault) begin
            state_reg <= QUAL_COUNT;
            cnt_reg   <= qual_delay;
          end
        end
        QUAL_COUNT: begin
          if (!fault) begin
            state_reg <= QUAL_IDLE;
          end else if (cnt_reg == 16'h0000) begin
            state_reg <= QUAL_ACTIVE;
            rise      <= 1'b1;
          end else if (tick) begin
            cnt_reg <= cnt_reg - 16'h0001;
          end
        end
        QUAL_ACTIVE: begin
          if (!fault) begin
            state_reg <= latch ? QUAL_LATCHED : QUAL_IDLE;
            fall      <= !latch;
          end
        end
        QUAL_LATCHED: begin
          if (fault) begin
            state_reg <= QUAL_ACTIVE;
          end else if (clear_req) begin
            state_reg <= QUAL_IDLE;
            fall      <= 1'b1;
          end
        end
      endcase
    end
  end

  assign active = (state_reg == QUAL_ACTIVE) || (state_reg == QUAL_LATCHED);

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_start;
    @(posedge core_clk) disable iff (!reset_n)
    core_ce && state_reg == QUAL_IDLE && fault |=>
      state_reg == QUAL_COUNT && cnt_reg == $past(qual_delay);
  endproperty
  a_start: assert property (p_start) else $error("countdown not started");

  property p_abandon;
    @(posedge core_clk) disable iff (!reset_n)
    core_ce && state_reg == QUAL_COUNT && !fault |=> !active && !rise;
  endproperty
  a_abandon: assert property (p_abandon) else $error("early fault qualified");

  property p_unlatched_drop;
    @(posedge core_clk) disable iff (!reset_n)
    core_ce && state_reg == QUAL_ACTIVE && !fault && !latch |=> !active && fall;
  endproperty
  a_unlatched_drop: assert property (p_unlatched_drop) else $error("code kept");

  property p_latch_hold;
    @(posedge core_clk) disable iff (!reset_n)
    active && latch && !clear_req |=> active;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched code lost");

endmodule : dtc_event_qualifier
`default_nettype wire

// File: src/dtc_manager.sv
// Purpose: Diagnostic trouble code manager with APB registers
// Assumes: NUM_EVENTS from 2 to 8, APB master per AMBA APB
// Notes:   DM1 leaves as a beat stream with valid and ready
//
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module dtc_manager import dtc_mgr_pkg::*; #(
  parameter int NUM_EVENTS     = N_EVENTS,
  parameter int HOLDOFF_CYCLES = HOLDOFF_CYC,
  parameter int PERIOD_CYCLES  = PERIOD_CYC,
  parameter int TICK_CYCLES    = TICK_CYC
) (
  // Clock, reset, enable
  input  wire logic                  core_clk,
  input  wire logic                  reset_n,
  input  wire logic                  core_ce,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Fault inputs and network clear requests
  input  wire logic [NUM_EVENTS-1:0] fault_in,
  input  wire logic                  dm11_clear_req,
  input  wire logic                  dm3_clear_req,
  // DM1 beat stream
  output dm1_beat_s                  dm1_beat,
  output logic                       dm1_valid,
  input  wire logic                  dm1_ready,
  // Non-volatile count write port
  output logic                       nv_we,
  output logic [2:0]                 nv_index,
  output logic [6:0]                 nv_count,
  // Interrupt
  output logic                       irq
);

  localparam int IW = $clog2(NUM_EVENTS);

  typedef enum logic [1:0] {SEND_IDLE, SEND_LOAD, SEND_WAIT} send_state_e;

  event_cfg_s              cfg_reg [NUM_EVENTS];
  logic [6:0]              occ_reg [NUM_EVENTS];
  logic [NUM_EVENTS-1:0]   active, rise, fall, spn_nz, report, prev_reg, dirty_reg;
  logic [NUM_EVENTS-1:0]   report_q_reg, mask_reg, occ_chg;
  logic [IRQ_W-1:0]        status_reg, irq_mask_reg, irq_set;
  logic [31:0]             tick_cnt_reg, hold_cnt_reg, period_cnt_reg, rdata;
  logic                    tick_reg, holdoff_done_reg, pending_reg, first_reg;
  logic                    wr_en, ev_hit, err, send_req, clr_active, clr_prev;
  logic [IW-1:0]           ev_idx, pick;
  logic [7:0]              lamp_byte;
  logic [3:0]              act_cnt;
  send_state_e             send_reg;

  // Lowest set bit of a vector
  function automatic logic [IW-1:0] first_set(input logic [NUM_EVENTS-1:0] v);
    first_set = '0;
    for (int k = NUM_EVENTS - 1; k >= 0; k--) begin
      if (v[k]) first_set = IW'(k);
    end
  endfunction : first_set

  // ****************************************************************
  // APB decode and read mux
  // ****************************************************************
  assign wr_en  = psel && penable && pwrite && pready && core_ce;
  assign ev_hit = (paddr >= ADDR_EVENT_BASE) &&
                  (paddr < ADDR_EVENT_BASE + 12'(8 * NUM_EVENTS)) && (paddr[1:0] == 2'b00);
  assign ev_idx = IW'((paddr - ADDR_EVENT_BASE) >> 3);

  // Read data and error for the access
  always_comb begin
    rdata = 32'h0000_0000;
    err   = 1'b0;
    if (ev_hit && paddr[2]) begin
      rdata = {1'b0, occ_reg[ev_idx], cfg_reg[ev_idx].delay, cfg_reg[ev_idx].latch,
               cfg_reg[ev_idx].lamp, cfg_reg[ev_idx].fmi};
    end else if (ev_hit) begin
      rdata = {13'h0000, cfg_reg[ev_idx].spn};
    end else begin
      unique case (paddr)
        ADDR_IRQ_STATUS: rdata = 32'(status_reg);
        ADDR_IRQ_MASK:   rdata = 32'(irq_mask_reg);
        ADDR_STATE:      rdata = 32'(active) | (32'(prev_reg) << 8) |
                                 (32'(holdoff_done_reg) << 16);
        ADDR_COMMAND:    rdata = 32'h0000_0000;
        default:         err   = 1'b1;
      endcase
    end
  end

  // No wait state: answer on the first access cycle
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (core_ce) begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && err;
      prdata  <= (psel && !penable && !pwrite) ? rdata : 32'h0000_0000;
    end
  end

  // Command strobes from software or the network
  assign clr_active = dm11_clear_req ||
                      (wr_en && !err && paddr == ADDR_COMMAND && pwdata[CMD_CLR_ACTIVE]);
  assign clr_prev   = dm3_clear_req ||
                      (wr_en && !err && paddr == ADDR_COMMAND && pwdata[CMD_CLR_PREV]);

  // ****************************************************************
  // Per-event configuration, qualifier and count
  // ****************************************************************
  for (genvar g = 0; g < NUM_EVENTS; g++) begin : g_event
    logic wr_spn, wr_ctrl;
    assign wr_spn  = wr_en && ev_hit && !paddr[2] && ev_idx == IW'(g);
    assign wr_ctrl = wr_en && ev_hit && paddr[2] && ev_idx == IW'(g);
    assign spn_nz[g]  = cfg_reg[g].spn != 19'h00000;
    assign report[g]  = active[g] && spn_nz[g];
    assign occ_chg[g] = (wr_spn && pwdata[18:0] != cfg_reg[g].spn) ||
                        (rise[g] && spn_nz[g] && occ_reg[g] != OC_MAX);

    // Setpoints; illegal failure modes are refused
    always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
        cfg_reg[g] <= '{SPN_RESET, FMI_RESET, LAMP_AMBER, 1'b0, DELAY_RESET};
      end else if (core_ce) begin
        if (wr_spn) cfg_reg[g].spn <= pwdata[18:0];
        if (wr_ctrl) begin
          if (fmi_legal(pwdata[4:0])) cfg_reg[g].fmi <= pwdata[4:0];
          cfg_reg[g].lamp  <= lamp_sel_e'(pwdata[CTRL_LAMP_LSB +: 2]);
          cfg_reg[g].latch <= pwdata[CTRL_LATCH_BIT];
          cfg_reg[g].delay <= pwdata[CTRL_DELAY_LSB +: 16];
        end
      end
    end

    // Occurrence count held for the non-volatile log
    always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
        occ_reg[g] <= 7'h00;
      end else if (core_ce) begin
        if (wr_spn && pwdata[18:0] != cfg_reg[g].spn) begin
          occ_reg[g] <= 7'h00;
        end else if (rise[g] && spn_nz[g] && occ_reg[g] != OC_MAX) begin
          occ_reg[g] <= occ_reg[g] + 7'h01;
        end
      end
    end

    dtc_event_qualifier u_qual (
      .core_clk   (core_clk),
      .reset_n    (reset_n),
      .core_ce    (core_ce),
      .tick       (tick_reg),
      .fault      (fault_in[g]),
      .qual_delay (cfg_reg[g].delay),
      .latch      (cfg_reg[g].latch),
      .clear_req  (clr_active),
      .active     (active[g]),
      .rise       (rise[g]),
      .fall       (fall[g])
    );

    property p_oc_reset;
      @(posedge core_clk) disable iff (!reset_n)
      wr_spn && pwdata[18:0] != cfg_reg[g].spn |=> occ_reg[g] == 7'h00;
    endproperty
    a_oc_reset: assert property (p_oc_reset) else $error("count not zeroed");
  end

  // Previously active codes and log write-back
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prev_reg  <= '0;
      dirty_reg <= '0;
      nv_we     <= 1'b0;
      nv_index  <= 3'h0;
      nv_count  <= 7'h00;
    end else if (core_ce) begin
      prev_reg  <= (prev_reg & ~rise & ~{NUM_EVENTS{clr_prev}}) | fall;
      nv_we     <= |dirty_reg;
      nv_index  <= 3'(first_set(dirty_reg));
      nv_count  <= occ_reg[first_set(dirty_reg)];
      dirty_reg <= (dirty_reg & ~(NUM_EVENTS'(|dirty_reg) << first_set(dirty_reg))) |
                   occ_chg;
    end
  end

  // ****************************************************************
  // Timers: tick, start-up hold-off, periodic send
  // ****************************************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt_reg     <= 32'h0000_0000;
      tick_reg         <= 1'b0;
      hold_cnt_reg     <= 32'h0000_0000;
      holdoff_done_reg <= 1'b0;
      period_cnt_reg   <= 32'h0000_0000;
    end else if (core_ce) begin
      tick_reg     <= tick_cnt_reg == 32'(TICK_CYCLES - 1);
      tick_cnt_reg <= (tick_cnt_reg == 32'(TICK_CYCLES - 1)) ? 32'h0 : tick_cnt_reg + 32'h1;
      if (!holdoff_done_reg) begin
        hold_cnt_reg     <= hold_cnt_reg + 32'h1;
        holdoff_done_reg <= hold_cnt_reg == 32'(HOLDOFF_CYCLES - 1);
      end else begin
        period_cnt_reg <= (period_cnt_reg == 32'(PERIOD_CYCLES - 1)) ? 32'h0 :
                          period_cnt_reg + 32'h1;
      end
    end
  end

  // ****************************************************************
  // Send requests and interrupt status
  // ****************************************************************
  assign send_req = |(rise & spn_nz) ||
                    (report_q_reg != '0 && report == '0) ||
                    (holdoff_done_reg && period_cnt_reg == 32'(PERIOD_CYCLES - 1)) ||
                    (wr_en && !err && paddr == ADDR_COMMAND && pwdata[CMD_SEND_DM1]);
  assign irq_set  = {dm1_valid && dm1_ready && dm1_beat.last,
                     report_q_reg != '0 && report == '0, |(rise & spn_nz)};

  // Pending request: a new request wins over the take
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pending_reg  <= 1'b1;
      report_q_reg <= '0;
      status_reg   <= '0;
      irq_mask_reg <= '0;
      irq          <= 1'b0;
    end else if (core_ce) begin
      pending_reg  <= send_req ||
                      (pending_reg && !(send_reg == SEND_IDLE && holdoff_done_reg));
      report_q_reg <= report;
      status_reg   <= (status_reg & ~((wr_en && paddr == ADDR_IRQ_STATUS) ?
                       pwdata[IRQ_W-1:0] : '0)) | irq_set;
      if (wr_en && paddr == ADDR_IRQ_MASK) irq_mask_reg <= pwdata[IRQ_W-1:0];
      irq          <= |(status_reg & irq_mask_reg);
    end
  end

  // ****************************************************************
  // DM1 assembly
  // ****************************************************************
  // Lamp byte and active count of the reported codes
  always_comb begin
    lamp_byte = 8'h00;
    act_cnt   = 4'h0;
    for (int k = 0; k < NUM_EVENTS; k++) begin
      if (report[k]) begin
        lamp_byte[{cfg_reg[k].lamp, 1'b0} +: 2] = 2'b01;
        act_cnt = act_cnt + 4'h1;
      end
    end
  end

  assign pick = first_set(mask_reg);

  // Beat sequencer: snapshot, then one code per beat
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      send_reg  <= SEND_IDLE;
      mask_reg  <= '0;
      first_reg <= 1'b0;
      dm1_valid <= 1'b0;
      dm1_beat  <= '0;
    end else if (core_ce) begin
      unique case (send_reg)
        SEND_IDLE: begin
          if (pending_reg && holdoff_done_reg) begin
            mask_reg             <= report;
            first_reg            <= 1'b1;
            dm1_beat.lamp        <= lamp_byte;
            dm1_beat.count       <= act_cnt;
            dm1_beat.multipacket <= act_cnt > 4'h1;
            send_reg             <= SEND_LOAD;
          end
        end
        SEND_LOAD: begin
          dm1_beat.first <= first_reg;
          dm1_valid      <= 1'b1;
          if (mask_reg == '0) begin
            dm1_beat.dtc  <= 32'h0000_0000;
            dm1_beat.last <= 1'b1;
          end else begin
            dm1_beat.dtc  <= {1'b0, occ_reg[pick], cfg_reg[pick].spn[18:16],
                              cfg_reg[pick].fmi, cfg_reg[pick].spn[15:0]};
            dm1_beat.last <= (mask_reg & ~(NUM_EVENTS'(1) << pick)) == '0;
            mask_reg      <= mask_reg & ~(NUM_EVENTS'(1) << pick);
          end
          send_reg <= SEND_WAIT;
        end
        SEND_WAIT: begin
          if (dm1_ready) begin
            dm1_valid <= 1'b0;
            first_reg <= 1'b0;
            send_reg  <= dm1_beat.last ? SEND_IDLE : SEND_LOAD;
          end
        end
        default: send_reg <= SEND_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_holdoff;
    @(posedge core_clk) disable iff (!reset_n)
    dm1_valid |-> holdoff_done_reg;
  endproperty
  a_holdoff: assert property (p_holdoff) else $error("DM1 during hold-off");

  property p_multipacket;
    @(posedge core_clk) disable iff (!reset_n)
    dm1_valid |-> dm1_beat.multipacket == (dm1_beat.count > 4'h1);
  endproperty
  a_multipacket: assert property (p_multipacket) else $error("bad multipacket");

  property p_cm_zero;
    @(posedge core_clk) disable iff (!reset_n)
    dm1_valid |-> !dm1_beat.dtc[31];
  endproperty
  a_cm_zero: assert property (p_cm_zero) else $error("conversion bit set");

  property p_spn_nz;
    @(posedge core_clk) disable iff (!reset_n)
    dm1_valid && dm1_beat.count != 4'h0 |->
      {dm1_beat.dtc[23:21], dm1_beat.dtc[15:0]} != 19'h00000 && dm1_beat.lamp != 8'h00;
  endproperty
  a_spn_nz: assert property (p_spn_nz) else $error("zero parameter sent");

  sequence s_new_code;
    core_ce && |(rise & spn_nz);
  endsequence
  property p_new_sends;
    @(posedge core_clk) disable iff (!reset_n)
    s_new_code |=> pending_reg ##[0:3] (send_reg != SEND_IDLE || !holdoff_done_reg);
  endproperty
  a_new_sends: assert property (p_new_sends) else $error("new code not sent");

endmodule : dtc_manager
`default_nettype wire

// File: tb/dm1_sink.sv
// Purpose: DM1 consumer on the network side
// Assumes: beats move on valid and ready
// Notes:   stall holds ready low for back-pressure
`timescale 1ns/1ps
`default_nettype none
module dm1_sink import dtc_mgr_pkg::*; (
  // Clock and reset
  input  wire logic      core_clk,
  input  wire logic      reset_n,
  // Stream
  input  wire dm1_beat_s dm1_beat,
  input  wire logic      dm1_valid,
  input  wire logic      stall,
  output logic           dm1_ready,
  // Capture
  output dm1_beat_s      seen_beat,
  output logic [7:0]     seen_cnt
);
  // Ready unless stalled
  assign dm1_ready = !stall;
  // Keep each accepted beat
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      seen_beat <= '0;
      seen_cnt  <= 8'h00;
    end else if (dm1_valid && dm1_ready) begin
      seen_beat <= dm1_beat;
      seen_cnt  <= seen_cnt + 8'h01;
    end
  end
endmodule : dm1_sink
`default_nettype wire

// File: tb/dtc_manager_tb.sv
// Purpose: Self-checking bench of the trouble code manager
// Assumes: short hold-off and tick parameters
// Notes:   periodic DM1 pushed beyond the run
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module dtc_manager_tb import dtc_mgr_pkg::*;;
  logic core_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, stall = 0, pready;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [7:0]  fault_in = 8'h00, seen_cnt, c;
  logic        pslverr, dm1_valid, dm1_ready, irq, e, nv_we;
  logic        dm11_req = 0, dm3_req = 0;
  logic [2:0]  nv_index;
  logic [6:0]  nv_count, nv0 = 7'h00;
  dm1_beat_s   dm1_beat, sb;
  int          err_total = 0, total_checks = 0;
  dtc_manager #(.HOLDOFF_CYCLES(50), .PERIOD_CYCLES(20000), .TICK_CYCLES(4)) i_dtc_manager (
    .core_clk(core_clk), .reset_n(reset_n), .core_ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fault_in(fault_in), .dm11_clear_req(dm11_req), .dm3_clear_req(dm3_req),
    .dm1_beat(dm1_beat), .dm1_valid(dm1_valid), .dm1_ready(dm1_ready), .nv_we(nv_we),
    .nv_index(nv_index), .nv_count(nv_count), .irq(irq));
  dm1_sink i_dm1_sink (.core_clk(core_clk), .reset_n(reset_n), .dm1_beat(dm1_beat),
    .dm1_valid(dm1_valid), .stall(stall), .dm1_ready(dm1_ready), .seen_beat(sb),
    .seen_cnt(seen_cnt));
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  // Last logged count of event 0
  always @(posedge core_clk) begin
    if (nv_we === 1'b1 && nv_index === 3'h0) nv0 <= nv_count;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  // One APB transfer, held until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    n = 0;
    do begin @(posedge core_clk); n++; end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
    @(posedge core_clk);
    if (n >= 50) begin err_total++; tally_and_finish(); end
  endtask : apb
  // Wait for the sink to count one more beat
  task automatic wait_beat();
    int n;
    for (n = 0; n < 3000 && seen_cnt === c; n++) @(posedge core_clk);
    if (n >= 3000) begin err_total++; tally_and_finish(); end
    c = seen_cnt;
  endtask : wait_beat
  task automatic s_holdoff();
    int v;
    v = 0;
    repeat (40) begin @(posedge core_clk); v += (dm1_valid !== 1'b0); end
    `CHK("early dm1", 0, v)
    wait_beat();
    `CHK("empty dm1", {1'b1, 1'b1, 1'b0, 8'h00, 4'h0, 32'h0}, sb)
    apb(0, ADDR_STATE, 0);
    `CHK("holdoff done", 1'b1, q[16])
    $display("test holdoff done");
  endtask : s_holdoff
  task automatic s_regs();
    apb(0, 12'h044, 0);
    `CHK("ctrl reset", 32'h0003e83f, q)
    apb(1, 12'h044, 32'h0003e836);
    apb(0, 12'h044, 0);
    `CHK("illegal fmi", 32'h0003e83f, q)
    apb(0, 12'hffc, 0);
    `CHK("unmapped", 1'b1, e)
    $display("test regs done");
  endtask : s_regs
  task automatic s_qualify();
    apb(1, ADDR_IRQ_MASK, 32'h1);
    apb(1, 12'h040, 32'h00012345);
    apb(1, 12'h044, 32'h00000243);
    apb(1, 12'h04c, 32'h0000013f);
    fault_in <= 8'h01;
    repeat (2) @(posedge core_clk);
    fault_in <= 8'h00;
    repeat (30) @(posedge core_clk);
    apb(0, ADDR_STATE, 0);
    `CHK("short fault", 8'h00, q[7:0])
    stall <= 1;
    fault_in <= 8'h03;
    repeat (60) @(posedge core_clk);
    `CHK("stalled beat", 1'b1, dm1_valid)
    stall <= 0;
    wait_beat();
    `CHK("dtc", 32'h01232345, sb.dtc)
    `CHK("lamp red", 8'h10, sb.lamp)
    `CHK("count", {1'b1, 1'b1, 1'b0, 4'h1}, {sb.first, sb.last, sb.multipacket, sb.count})
    `CHK("irq", 1'b1, irq)
    apb(1, ADDR_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge core_clk);
    `CHK("irq clear", 1'b0, irq)
    $display("test qualify done");
  endtask : s_qualify
  task automatic s_clear();
    fault_in <= 8'h00;
    wait_beat();
    `CHK("none left", {4'h0, 32'h0}, {sb.count, sb.dtc})
    apb(0, ADDR_STATE, 0);
    `CHK("prev active", 16'h0300, q[15:0])
    $display("test clear done");
  endtask : s_clear
  task automatic s_latch();
    apb(1, 12'h048, 32'h00000abc);
    apb(1, 12'h04c, 32'h00000265);
    apb(1, 12'h044, 32'h000002c3);
    fault_in <= 8'h03;
    wait_beat();
    `CHK("pkt first", {1'b1, 1'b0, 1'b1, 8'h50, 4'h2, 32'h02232345}, sb)
    wait_beat();
    `CHK("pkt last", {1'b0, 1'b1, 1'b1, 8'h50, 4'h2, 32'h01050abc}, sb)
    `CHK("oc log", 7'h02, nv0)
    fault_in <= 8'h00;
    repeat (4) @(posedge core_clk);
    apb(0, ADDR_STATE, 0);
    `CHK("latched", 16'h0201, q[15:0])
    dm11_req <= 1;
    @(posedge core_clk);
    dm11_req <= 0;
    wait_beat();
    `CHK("dm11 empty", {8'h00, 4'h0, 32'h0}, {sb.lamp, sb.count, sb.dtc})
    apb(0, ADDR_STATE, 0);
    `CHK("dm11 prev", 16'h0300, q[15:0])
    dm3_req <= 1;
    @(posedge core_clk);
    dm3_req <= 0;
    apb(0, ADDR_STATE, 0);
    `CHK("dm3 prev", 8'h00, q[15:8])
    $display("test latch done");
  endtask : s_latch
  initial begin
    c = 8'h00;
    repeat (12) @(posedge core_clk);
    reset_n <= 1;
    s_holdoff();
    s_regs();
    s_qualify();
    s_clear();
    s_latch();
    tally_and_finish();
  end
endmodule : dtc_manager_tb
`default_nettype wire
